// *** src/pirqep_core.sv ***
// peripheral interrupt enable, priority and request routing
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ns
// Behaviour
// - enable one: eight rw bits, reset zero
// - enable two: bits 5-4 unimplemented, read zero
// - enable three: serial2 read-only zero, capture3 rw
// - enable one passes flag, zero masks it
// - priority one: eight rw bits, reset one
// - priority two: reset one, bits 5-4 zero
// - priority one high request, zero low
// - priority bits matter only with levels on
// - single level needs peripheral group enable
// - flags set regardless of any enable
// - levels-on bit seven of control, reset zero
module pirqep_core (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // peripheral events, one-cycle or level, same clock
  input wire logic [7:0] srcEventOne,
  input wire logic [7:0] srcEventTwo,
  input wire logic [7:0] srcEventThree,
  // requests toward the core
  output logic irqHigh,
  output logic irqLow,
  output logic irqAny
);
  import pirqep_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] enableOne, enableTwo, enableThree;
  logic [7:0] priorityOne, priorityTwo, control;
  logic [7:0] flagOne, flagTwo, flagThree;
  logic [7:0] next_enableOne, next_enableTwo, next_enableThree;
  logic [7:0] next_priorityOne, next_priorityTwo, next_control;
  logic [7:0] next_flagOne, next_flagTwo, next_flagThree;
  logic [7:0] next_regRdData;
  logic next_irqHigh, next_irqLow, next_irqAny;
  // one named bit per source, read by the routing below
  logic parportAccessEn;
  logic conversionDoneEn;
  logic serial1RxEn;
  logic serial1TxEn;
  logic syncSerialEn;
  logic capture1En;
  logic timer2MatchEn;
  logic timer1OvfEn;
  logic clockFailEn;
  logic comparatorChangeEn;
  logic busCollisionEn;
  logic voltageDetectEn;
  logic timer3OvfEn;
  logic capture2En;
  logic serial2RxEn;
  logic serial2TxEn;
  logic capture3En;
  logic parportAccessPrio;
  logic conversionDonePrio;
  logic serial1RxPrio;
  logic serial1TxPrio;
  logic syncSerialPrio;
  logic capture1Prio;
  logic timer2MatchPrio;
  logic timer1OvfPrio;
  logic clockFailPrio;
  logic comparatorChangePrio;
  logic busCollisionPrio;
  logic voltageDetectPrio;
  logic timer3OvfPrio;
  logic capture2Prio;
  logic priorityLevelsOn;
  logic peripheralGroupEn;

  // masked write keeps bits outside the mask unchanged
  function automatic logic [7:0] mergeWrite(input logic [7:0] old, input logic [7:0] data,
                                            input logic [7:0] mask);
    mergeWrite = (old & ~mask) | (data & mask);
  endfunction

  // write-one-to-clear with a same-cycle event winning over the clear
  function automatic logic [7:0] stickyFlag(input logic [7:0] old, input logic clr,
                                            input logic [7:0] data, input logic [7:0] ev,
                                            input logic [7:0] mask);
    logic [7:0] cleared;
    cleared = clr ? (old & ~data) : old;
    stickyFlag = (cleared | ev) & mask;
  endfunction

  // strobe aimed at one register index
  function automatic logic hit(input logic strobe, input logic [3:0] addr, input logic [3:0] target);
    hit = strobe && (addr == target);
  endfunction

  // one source: pending only while enabled, then steered by its priority bit
  function automatic logic [1:0] route(input logic flag, input logic en, input logic prio);
    route = {flag & en & prio, flag & en & ~prio};
  endfunction

  // ----------------------------------------------------------------
  // enable, priority and control writes
  // ----------------------------------------------------------------
  always_comb begin
    next_enableOne = enableOne;
    next_enableTwo = enableTwo;
    next_enableThree = enableThree;
    next_priorityOne = priorityOne;
    next_priorityTwo = priorityTwo;
    next_control = control;
    if (regWrite) begin
      case (regAddr)
        ADDR_ENABLE_ONE: begin
          next_enableOne = mergeWrite(enableOne, regWrData, MASK_ONE);
        end
        ADDR_ENABLE_TWO: begin
          next_enableTwo = mergeWrite(enableTwo, regWrData, MASK_TWO);
        end
        ADDR_ENABLE_THREE: begin
          // serial2 enables stay zero: read-only in this group
          next_enableThree = mergeWrite(enableThree, regWrData, WRITE_MASK_THREE);
        end
        ADDR_PRIORITY_ONE: begin
          next_priorityOne = mergeWrite(priorityOne, regWrData, MASK_ONE);
        end
        ADDR_PRIORITY_TWO: begin
          next_priorityTwo = mergeWrite(priorityTwo, regWrData, MASK_TWO);
        end
        ADDR_CONTROL: begin
          next_control = mergeWrite(control, regWrData, MASK_CONTROL);
        end
        default: begin
          next_control = control;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sticky flags
  // ----------------------------------------------------------------
  always_comb begin
    // flags latch whatever the enables say, so software can poll
    next_flagOne = stickyFlag(flagOne, hit(regWrite, regAddr, ADDR_FLAG_ONE),
                              regWrData, srcEventOne, MASK_ONE);
    next_flagTwo = stickyFlag(flagTwo, hit(regWrite, regAddr, ADDR_FLAG_TWO),
                              regWrData, srcEventTwo, MASK_TWO);
    next_flagThree = stickyFlag(flagThree, hit(regWrite, regAddr, ADDR_FLAG_THREE),
                                regWrData, srcEventThree, MASK_THREE);
  end

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always_comb begin
    next_regRdData = 8'h00;
    if (regRead) begin
      case (regAddr)
        ADDR_ENABLE_ONE: next_regRdData = enableOne;
        ADDR_ENABLE_TWO: next_regRdData = enableTwo & MASK_TWO;
        ADDR_ENABLE_THREE: next_regRdData = enableThree & MASK_THREE;
        ADDR_PRIORITY_ONE: next_regRdData = priorityOne;
        ADDR_PRIORITY_TWO: next_regRdData = priorityTwo & MASK_TWO;
        ADDR_CONTROL: next_regRdData = control & MASK_CONTROL;
        ADDR_FLAG_ONE: next_regRdData = flagOne;
        ADDR_FLAG_TWO: next_regRdData = flagTwo;
        ADDR_FLAG_THREE: next_regRdData = flagThree;
        default: next_regRdData = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // named fields
  // ----------------------------------------------------------------
  always_comb begin
    parportAccessEn = enableOne[BIT_PARPORT_ACCESS];
    conversionDoneEn = enableOne[BIT_CONVERSION_DONE];
    serial1RxEn = enableOne[BIT_SERIAL1_RX];
    serial1TxEn = enableOne[BIT_SERIAL1_TX];
    syncSerialEn = enableOne[BIT_SYNC_SERIAL];
    capture1En = enableOne[BIT_CAPTURE1];
    timer2MatchEn = enableOne[BIT_TIMER2_MATCH];
    timer1OvfEn = enableOne[BIT_TIMER1_OVF];
    clockFailEn = enableTwo[BIT_CLOCK_FAIL];
    comparatorChangeEn = enableTwo[BIT_COMPARATOR_CHANGE];
    busCollisionEn = enableTwo[BIT_BUS_COLLISION];
    voltageDetectEn = enableTwo[BIT_VOLTAGE_DETECT];
    timer3OvfEn = enableTwo[BIT_TIMER3_OVF];
    capture2En = enableTwo[BIT_CAPTURE2];
    serial2RxEn = enableThree[BIT_SERIAL2_RX];
    serial2TxEn = enableThree[BIT_SERIAL2_TX];
    capture3En = enableThree[BIT_CAPTURE3];
    parportAccessPrio = priorityOne[BIT_PARPORT_ACCESS];
    conversionDonePrio = priorityOne[BIT_CONVERSION_DONE];
    serial1RxPrio = priorityOne[BIT_SERIAL1_RX];
    serial1TxPrio = priorityOne[BIT_SERIAL1_TX];
    syncSerialPrio = priorityOne[BIT_SYNC_SERIAL];
    capture1Prio = priorityOne[BIT_CAPTURE1];
    timer2MatchPrio = priorityOne[BIT_TIMER2_MATCH];
    timer1OvfPrio = priorityOne[BIT_TIMER1_OVF];
    clockFailPrio = priorityTwo[BIT_CLOCK_FAIL];
    comparatorChangePrio = priorityTwo[BIT_COMPARATOR_CHANGE];
    busCollisionPrio = priorityTwo[BIT_BUS_COLLISION];
    voltageDetectPrio = priorityTwo[BIT_VOLTAGE_DETECT];
    timer3OvfPrio = priorityTwo[BIT_TIMER3_OVF];
    capture2Prio = priorityTwo[BIT_CAPTURE2];
    priorityLevelsOn = control[BIT_PRIORITY_LEVELS_ON];
    peripheralGroupEn = control[BIT_PERIPHERAL_GROUP_EN];
  end

  // ----------------------------------------------------------------
  // request routing
  // ----------------------------------------------------------------
  logic [1:0] req;
  logic highAny, lowAny;
  always_comb begin
    // group three has no priority register, so its sources use the fixed level
    req = 2'h0;
    req = req | route(flagOne[BIT_PARPORT_ACCESS], parportAccessEn, parportAccessPrio);
    req = req | route(flagOne[BIT_CONVERSION_DONE], conversionDoneEn, conversionDonePrio);
    req = req | route(flagOne[BIT_SERIAL1_RX], serial1RxEn, serial1RxPrio);
    req = req | route(flagOne[BIT_SERIAL1_TX], serial1TxEn, serial1TxPrio);
    req = req | route(flagOne[BIT_SYNC_SERIAL], syncSerialEn, syncSerialPrio);
    req = req | route(flagOne[BIT_CAPTURE1], capture1En, capture1Prio);
    req = req | route(flagOne[BIT_TIMER2_MATCH], timer2MatchEn, timer2MatchPrio);
    req = req | route(flagOne[BIT_TIMER1_OVF], timer1OvfEn, timer1OvfPrio);
    req = req | route(flagTwo[BIT_CLOCK_FAIL], clockFailEn, clockFailPrio);
    req = req | route(flagTwo[BIT_COMPARATOR_CHANGE], comparatorChangeEn, comparatorChangePrio);
    req = req | route(flagTwo[BIT_BUS_COLLISION], busCollisionEn, busCollisionPrio);
    req = req | route(flagTwo[BIT_VOLTAGE_DETECT], voltageDetectEn, voltageDetectPrio);
    req = req | route(flagTwo[BIT_TIMER3_OVF], timer3OvfEn, timer3OvfPrio);
    req = req | route(flagTwo[BIT_CAPTURE2], capture2En, capture2Prio);
    req = req | route(flagThree[BIT_SERIAL2_RX], serial2RxEn, FIXED_PRIORITY_THREE[BIT_SERIAL2_RX]);
    req = req | route(flagThree[BIT_SERIAL2_TX], serial2TxEn, FIXED_PRIORITY_THREE[BIT_SERIAL2_TX]);
    req = req | route(flagThree[BIT_CAPTURE3], capture3En, FIXED_PRIORITY_THREE[BIT_CAPTURE3]);
    highAny = req[1];
    lowAny = req[0];
    if (priorityLevelsOn) begin
      next_irqHigh = highAny;
      next_irqLow = lowAny;
    end else begin
      // single level: priority bits ignored, one merged request
      next_irqHigh = (highAny | lowAny) & peripheralGroupEn;
      next_irqLow = 1'b0;
    end
    next_irqAny = next_irqHigh | next_irqLow;
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enableOne <= RESET_ENABLE;
      enableTwo <= RESET_ENABLE;
      enableThree <= RESET_ENABLE;
      priorityOne <= RESET_PRIORITY_ONE;
      priorityTwo <= RESET_PRIORITY_TWO;
      control <= RESET_CONTROL;
    end else begin
      enableOne <= next_enableOne;
      enableTwo <= next_enableTwo;
      enableThree <= next_enableThree;
      priorityOne <= next_priorityOne;
      priorityTwo <= next_priorityTwo;
      control <= next_control;
    end
  end

  // ----------------------------------------------------------------
  // flag registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flagOne <= RESET_FLAG;
      flagTwo <= RESET_FLAG;
      flagThree <= RESET_FLAG;
    end else begin
      flagOne <= next_flagOne;
      flagTwo <= next_flagTwo;
      flagThree <= next_flagThree;
    end
  end

  // ----------------------------------------------------------------
  // read data register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= next_regRdData;
    end
  end

  // ----------------------------------------------------------------
  // request registers
  // ----------------------------------------------------------------
  // registered so the core never sees a glitch from the and-or tree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irqHigh <= 1'b0;
      irqLow <= 1'b0;
      irqAny <= 1'b0;
    end else begin
      irqHigh <= next_irqHigh;
      irqLow <= next_irqLow;
      irqAny <= next_irqAny;
    end
  end
endmodule

// *** src/pirqep_pkg.sv ***
// constants for the peripheral interrupt enable and priority block
package pirqep_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_ENABLE_ONE = 4'h0;
  localparam logic [3:0] ADDR_ENABLE_TWO = 4'h1;
  localparam logic [3:0] ADDR_ENABLE_THREE = 4'h2;
  localparam logic [3:0] ADDR_PRIORITY_ONE = 4'h3;
  localparam logic [3:0] ADDR_PRIORITY_TWO = 4'h4;
  localparam logic [3:0] ADDR_CONTROL = 4'h5;
  localparam logic [3:0] ADDR_FLAG_ONE = 4'h6;
  localparam logic [3:0] ADDR_FLAG_TWO = 4'h7;
  localparam logic [3:0] ADDR_FLAG_THREE = 4'h8;
  // ----------------------------------------------------------------
  // implemented and writable bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_ONE = 8'hFF;
  localparam logic [7:0] MASK_TWO = 8'hCF;
  localparam logic [7:0] MASK_THREE = 8'h31;
  localparam logic [7:0] WRITE_MASK_THREE = 8'h01;
  localparam logic [7:0] MASK_CONTROL = 8'hC0;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_PRIORITY_LEVELS_ON = 7;
  localparam int BIT_PERIPHERAL_GROUP_EN = 6;
  // source positions, shared by the enable, priority and flag registers
  localparam int BIT_PARPORT_ACCESS = 7;
  localparam int BIT_CONVERSION_DONE = 6;
  localparam int BIT_SERIAL1_RX = 5;
  localparam int BIT_SERIAL1_TX = 4;
  localparam int BIT_SYNC_SERIAL = 3;
  localparam int BIT_CAPTURE1 = 2;
  localparam int BIT_TIMER2_MATCH = 1;
  localparam int BIT_TIMER1_OVF = 0;
  localparam int BIT_CLOCK_FAIL = 7;
  localparam int BIT_COMPARATOR_CHANGE = 6;
  localparam int BIT_BUS_COLLISION = 3;
  localparam int BIT_VOLTAGE_DETECT = 2;
  localparam int BIT_TIMER3_OVF = 1;
  localparam int BIT_CAPTURE2 = 0;
  localparam int BIT_SERIAL2_RX = 5;
  localparam int BIT_SERIAL2_TX = 4;
  localparam int BIT_CAPTURE3 = 0;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_ENABLE = 8'h00;
  localparam logic [7:0] RESET_PRIORITY_ONE = 8'hFF;
  localparam logic [7:0] RESET_PRIORITY_TWO = 8'hCF;
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_FLAG = 8'h00;
  // sources of the third group have no priority register; they sit high
  localparam logic [7:0] FIXED_PRIORITY_THREE = 8'h31;
endpackage

// *** verification/peripheral_irq_enable_priority_bench.sv ***
// self-checking bench for the enable and priority block
`timescale 1ns/1ns
module peripheral_irq_enable_priority_bench;
  import pirqep_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, irqHigh, irqLow, irqAny;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00, regRdData, ev1, ev2, ev3, rnd;
  logic [23:0] fire = 24'h000000;
  int n_mismatch = 0, n_checks = 0;
  pirqep_core i_pirqep_core(.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .srcEventOne(ev1), .srcEventTwo(ev2),
    .srcEventThree(ev3), .irqHigh(irqHigh), .irqLow(irqLow), .irqAny(irqAny));
  pirqep_periph_model i_pirqep_periph_model(.clk_sys(clk_sys), .rst_n(rst_n), .fire(fire),
    .srcEventOne(ev1), .srcEventTwo(ev2), .srcEventThree(ev3));
  initial forever #5 clk_sys = ~clk_sys;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // writable bits of the enable and priority registers
  function automatic logic [7:0] wmask(input logic [3:0] a);
    return (a == 4'h1 || a == 4'h4) ? 8'hCF : (a == 4'h2) ? 8'h01 : 8'hFF;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regRead <= 1'b0;
    regAddr <= a;
    regWrData <= d;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regWrite <= 1'b0;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(negedge clk_sys);
    chk(regRdData, exp);
  endtask
  // idle cycles; also the only place that drives the event requests
  task automatic nop(input int n, input logic [23:0] f);
    @(posedge clk_sys);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    fire <= f;
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    logic [3:0] a;
    logic [7:0] m;
    rnd = 8'h35;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) rd(4'(i), i == 3 ? 8'hFF : i == 4 ? 8'hCF : 8'h00);
    rnd = lfsr(rnd);
    nop(0, {rnd, ~rnd, rnd});
    nop(0, 24'h000000);
    rd(ADDR_FLAG_ONE, rnd);
    rd(ADDR_FLAG_TWO, ~rnd & 8'hCF);
    rd(ADDR_FLAG_THREE, rnd & 8'h31);
    chk({7'h00, irqAny}, 8'h00);
    for (int g = 6; g < 9; g++) wr(4'(g), 8'hFF);
    for (int i = 0; i < 15; i++) begin
      a = 4'(i % 5);
      rnd = lfsr(rnd);
      wr(a, rnd);
      rd(a, rnd & wmask(a));
    end
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    wr(ADDR_CONTROL, 8'hFF);
    rd(ADDR_CONTROL, 8'hC0);
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      m = 8'h01 << rnd[2:0];
      wr(ADDR_ENABLE_ONE, i[0] ? m : ~m);
      wr(ADDR_PRIORITY_ONE, i[1] ? m : ~m);
      wr(ADDR_CONTROL, {i[3], i[2], 6'h00});
      nop(0, {16'h0000, m});
      nop(0, 24'h000000);
      rd(ADDR_FLAG_ONE, m);
      chk({7'h00, irqHigh}, {7'h00, i[0] & (i[3] ? i[1] : i[2])});
      chk({7'h00, irqLow}, {7'h00, i[0] & i[3] & !i[1]});
      chk({7'h00, irqAny}, {7'h00, i[0] & (i[3] | i[2])});
      wr(ADDR_FLAG_ONE, m);
      nop(2, 24'h000000);
      chk({7'h00, irqAny}, 8'h00);
    end
    // groups two and three: priority two steers, serial2 enables stay off
    wr(ADDR_ENABLE_ONE, 8'h00);
    wr(ADDR_ENABLE_TWO, 8'hFF);
    wr(ADDR_ENABLE_THREE, 8'hFF);
    wr(ADDR_PRIORITY_TWO, 8'h00);
    wr(ADDR_CONTROL, 8'h80);
    nop(0, {8'h30, 8'h08, 8'h00});
    nop(0, 24'h000000);
    rd(ADDR_FLAG_THREE, 8'h30);
    chk({5'h00, irqAny, irqHigh, irqLow}, 8'h05);
    wr(ADDR_FLAG_TWO, 8'h08);
    nop(0, {8'h01, 16'h0000});
    nop(0, 24'h000000);
    rd(ADDR_FLAG_THREE, 8'h31);
    chk({5'h00, irqAny, irqHigh, irqLow}, 8'h06);
    test_done;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    test_done;
  end
endmodule
bind pirqep_core pirqep_core_asserts i_pirqep_core_asserts(.clk_sys(clk_sys), .rst_n(rst_n), .regWrite(regWrite),
  .regRead(regRead), .irqHigh(irqHigh), .irqLow(irqLow), .irqAny(irqAny), .regAddr(regAddr), .regWrData(regWrData),
  .regRdData(regRdData), .srcEventOne(srcEventOne), .srcEventTwo(srcEventTwo), .srcEventThree(srcEventThree));

// *** verification/pirqep_core_asserts.sv ***
// port assertions for the enable and priority block
`timescale 1ns/1ns
module pirqep_core_asserts import pirqep_pkg::*; (
  input wire logic clk_sys, rst_n, regWrite, regRead, irqHigh, irqLow, irqAny,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData, regRdData, srcEventOne, srcEventTwo, srcEventThree
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // control shadow rebuilt from writes, since the checker sees no state
  logic [1:0] ctl, next_ctl;
  always_comb next_ctl = (regWrite && regAddr == ADDR_CONTROL) ? regWrData[7:6] : ctl;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) ctl <= 2'h0;
    else ctl <= next_ctl;
  end
  property wr_rd(a);
    (regWrite && regAddr == a) ##1 (regRead && regAddr == a) |=> regRdData == $past(regWrData, 2);
  endproperty
  a_rd_idle: assert property (!$past(regRead) |-> regRdData == 8'h00) else $error("idle read");
  a_any_or: assert property (irqAny == (irqHigh | irqLow)) else $error("any");
  a_en3_gap: assert property ($past(regRead && regAddr == ADDR_ENABLE_THREE) |->
    regRdData[7:1] == 7'h00) else $error("enable three");
  a_two_gap: assert property ($past(regRead && (regAddr == ADDR_ENABLE_TWO ||
    regAddr == ADDR_PRIORITY_TWO)) |-> regRdData[5:4] == 2'h0) else $error("gap bits");
  a_wr_rd_en: assert property (wr_rd(ADDR_ENABLE_ONE)) else $error("enable one");
  a_wr_rd_prio: assert property (wr_rd(ADDR_PRIORITY_ONE)) else $error("priority one");
  a_low_off: assert property (!ctl[1] && !$past(ctl[1]) |-> !irqLow) else $error("low");
  a_group_gate: assert property (ctl == 2'h0 && $past(ctl) == 2'h0 |-> !irqHigh) else $error("gate");
  a_flag_poll: assert property ((srcEventOne != 8'h00) ##1 (regRead && regAddr == ADDR_FLAG_ONE) |=>
    (regRdData & $past(srcEventOne, 2)) == $past(srcEventOne, 2)) else $error("flag");
  c_high: cover property (irqHigh && !irqLow);
  c_low: cover property (irqLow);
  c_poll: cover property (regRead && regAddr == ADDR_FLAG_ONE);
endmodule

// *** verification/pirqep_periph_model.sv ***
// peripherals: bench requests become source events one cycle later, as long as the bench holds them
`timescale 1ns/1ns
module pirqep_periph_model (
  // clock, reset, requests
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [23:0] fire,
  // events toward the block
  output logic [7:0] srcEventOne,
  output logic [7:0] srcEventTwo,
  output logic [7:0] srcEventThree
);
  // registered copy of fire; the bench pulses it, so a missed clear is not hidden by a stuck source
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) {srcEventThree, srcEventTwo, srcEventOne} <= 24'h000000;
    else {srcEventThree, srcEventTwo, srcEventOne} <= fire;
  end
endmodule
